// File: hdl/dpb_pkg.sv
/*
 * Shared constants and types of the parallel-to-serial debug bridge.
 * Assumes a 40 MHz system clock.
 */
package dpb_pkg;

    // Control/status register layout, bit 7 first
    typedef struct packed {
        logic reset_seen;     // Bit 7, target in soft or hard reset
        logic cut_flag;       // Bit 6, last byte cut by target reset
        logic halted;         // Bit 5, target in debug mode
        logic [1:0] divider;  // Bits 4..3, serial clock divider
        logic status_req_n;   // Bit 2, low asks for a status read
        logic loopback_n;     // Bit 1, low selects loopback
        logic halt_entry_n;   // Bit 0, low halts after soft reset
    } dpb_csr_t;

    localparam dpb_csr_t CSR_RESET = '{
        reset_seen: 1'b1, cut_flag: 1'b0, halted: 1'b0, divider: 2'h0,
        status_req_n: 1'b0, loopback_n: 1'b0, halt_entry_n: 1'b0};

    // Host access decode of the data/control select line
    localparam logic SEL_CONTROL = 1'b0;
    localparam logic SEL_DATA = 1'b1;
    localparam logic [1:0] RUN_STATE_HALTED = 2'h3;

    // Serial clock periods per divider code, in picoseconds
    localparam int unsigned MCLK_PS = 25000;
    localparam int unsigned SCK_PS_00 = 100000;   // 10 MHz
    localparam int unsigned SCK_PS_01 = 200000;   // 5 MHz
    localparam int unsigned SCK_PS_10 = 400000;   // 2.5 MHz
    localparam int unsigned SCK_PS_11 = 800000;   // 1.25 MHz
    localparam int unsigned HALF_00 = SCK_PS_00 / (2 * MCLK_PS);
    localparam int unsigned HALF_01 = SCK_PS_01 / (2 * MCLK_PS);
    localparam int unsigned HALF_10 = SCK_PS_10 / (2 * MCLK_PS);
    localparam int unsigned HALF_11 = SCK_PS_11 / (2 * MCLK_PS);

    // Reset configuration window in target system clocks
    localparam int unsigned CFG_PRE_SYSCLK = 3;
    localparam int unsigned CFG_POST_SYSCLK = 8;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    typedef enum logic [1:0] {
        DPB_IDLE = 2'b00,
        DPB_WAIT = 2'b01,
        DPB_SHIFT = 2'b10
    } dpb_xfer_t;

    typedef enum logic [1:0] {
        DPB_SR_OFF = 2'b00,
        DPB_SR_HOLD = 2'b01,
        DPB_SR_PRE = 2'b10,
        DPB_SR_POST = 2'b11
    } dpb_srst_t;

endpackage

// File: hdl/dpb_bridge.sv
/*
 * Parallel-to-serial debug bridge: host byte port in, full-duplex
 * serial debug port out, plus soft/hard reset control of the target.
 * Assumes all inputs synchronous to MCLK and the target's reset and
 * run-state lines already levelled to logic values.
 */
`timescale 1ns/10ps

module dpb_bridge #(
    parameter int unsigned SYS_PS = 25000,
    parameter int unsigned HALF_W = 5
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic HOST_CONNECTED,
    input wire logic [2:0] BOARD_ADDR,
    input wire logic [2:0] HOST_BOARD_SEL,
    input wire logic HOST_DATA_SEL,
    input wire logic HOST_STB,
    input wire logic HOST_WR,
    input wire logic [7:0] HOST_WDATA,
    input wire logic HOST_SOFT_RESET,
    input wire logic HOST_HARD_RESET,
    output logic [7:0] HOST_RDATA,
    output logic HOST_RVALID,
    output logic HOST_WREADY,
    output logic HOST_REQUEST_LINE,
    output logic XFER_BUSY,
    input wire logic TARGET_SOFT_RESET_N_IN,
    input wire logic TARGET_HRESET_N_IN,
    input wire logic [1:0] TARGET_RUN_STATE_PAIR,
    input wire logic SERIAL_DATA_FROM_TARGET,
    output logic SERIAL_DEBUG_CLOCK_O,
    output logic SERIAL_DEBUG_CLOCK_OE,
    output logic SERIAL_DATA_TO_TARGET_O,
    output logic SERIAL_DATA_TO_TARGET_OE,
    output logic SOFT_RESET_LINE_O,
    output logic SOFT_RESET_LINE_OE,
    output logic HARD_RESET_LINE_O,
    output logic HARD_RESET_LINE_OE
);

    localparam int unsigned PRE_CYC = (dpb_pkg::CFG_PRE_SYSCLK * SYS_PS
        + dpb_pkg::MCLK_PS - 1) / dpb_pkg::MCLK_PS;
    localparam int unsigned POST_CYC = (dpb_pkg::CFG_POST_SYSCLK * SYS_PS
        + dpb_pkg::MCLK_PS - 1) / dpb_pkg::MCLK_PS;

    // Refuse settings the counters cannot hold
    if (SYS_PS == 0 || HALF_W < 5 || HALF_W > 16 ||
        dpb_pkg::HALF_11 >= (1 << HALF_W) ||
        PRE_CYC > 65535 || POST_CYC > 65535) begin : g_bad_param
        $error("dpb_bridge: unsupported parameter values");
    end

    typedef struct packed {
        dpb_pkg::dpb_csr_t csr;
        dpb_pkg::dpb_xfer_t xfer;
        dpb_pkg::dpb_srst_t srst;
        logic [15:0] srst_cnt;
        logic [HALF_W-1:0] half_cnt;
        logic [3:0] bit_cnt;
        logic [7:0] tx_shift;
        logic [7:0] rx_shift;
        logic [7:0] rx_data;
        logic [1:0][7:0] buf_word;
        logic [1:0] buf_cnt;
        logic [7:0] rdata;
        logic rvalid;
        logic wready;
        logic busy;
        logic req;
        logic sck;
        logic sck_oe;
        logic sdo;
        logic sdo_oe;
        logic soft_line_oe;
        logic hreset_oe;
    } dpb_state_t;

    localparam dpb_state_t STATE_RESET = '{
        csr: dpb_pkg::CSR_RESET, xfer: dpb_pkg::DPB_IDLE,
        srst: dpb_pkg::DPB_SR_OFF, srst_cnt: 16'h0000, half_cnt: '0,
        bit_cnt: 4'h0, tx_shift: 8'h00, rx_shift: 8'h00, rx_data: 8'h00,
        buf_word: '0, buf_cnt: 2'h0, rdata: 8'h00, rvalid: 1'b0,
        wready: 1'b0, busy: 1'b0, req: 1'b0, sck: 1'b0, sck_oe: 1'b0,
        sdo: 1'b0, sdo_oe: 1'b0, soft_line_oe: 1'b0, hreset_oe: 1'b0};

    dpb_state_t st_r;
    dpb_state_t st_nxt;

    // Half period of the serial clock for the selected divider
    function automatic logic [HALF_W-1:0] half_of(input logic [1:0] d);
        logic [HALF_W-1:0] h;
        h = '0;
        unique case (d)
            2'h0: h = HALF_W'(dpb_pkg::HALF_00);
            2'h1: h = HALF_W'(dpb_pkg::HALF_01);
            2'h2: h = HALF_W'(dpb_pkg::HALF_10);
            2'h3: h = HALF_W'(dpb_pkg::HALF_11);
        endcase
        return h;
    endfunction

    logic selected;
    logic access;
    logic push;
    logic pop;
    logic target_rst;
    logic looped;
    logic rx_bit;
    logic cfg_drive;

    always_comb begin
        // Host decode, gated by cable presence and board address
        selected = HOST_CONNECTED && (HOST_BOARD_SEL == BOARD_ADDR);
        access = HOST_STB && selected;
        push = access && HOST_WR && (HOST_DATA_SEL == dpb_pkg::SEL_DATA)
            && st_r.wready;
        target_rst = !TARGET_SOFT_RESET_N_IN || !TARGET_HRESET_N_IN;
        looped = !st_r.csr.loopback_n;
        // Loopback feeds our own output back into the receiver
        rx_bit = looped ? st_r.sdo : SERIAL_DATA_FROM_TARGET;
        cfg_drive = st_r.srst != dpb_pkg::DPB_SR_OFF;
        pop = 1'b0;

        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;

        // Status bits follow the target every cycle
        st_nxt.csr.reset_seen = target_rst;
        st_nxt.csr.halted = TARGET_RUN_STATE_PAIR ==
            dpb_pkg::RUN_STATE_HALTED;

        // Register accesses; data writes refused while buffer is full
        if (access) begin
            if (HOST_WR) begin
                if (HOST_DATA_SEL == dpb_pkg::SEL_CONTROL) begin
                    st_nxt.csr.divider = HOST_WDATA[4:3];
                    st_nxt.csr.status_req_n = HOST_WDATA[2];
                    st_nxt.csr.loopback_n = HOST_WDATA[1];
                    st_nxt.csr.halt_entry_n = HOST_WDATA[0];
                end
            end else begin
                st_nxt.rvalid = 1'b1;
                st_nxt.rdata = (HOST_DATA_SEL == dpb_pkg::SEL_DATA) ?
                    st_r.rx_data : st_r.csr;
            end
        end

        // Serial engine, one byte per buffered word
        unique case (st_r.xfer)
            dpb_pkg::DPB_IDLE: begin
                st_nxt.sck = 1'b0;
                if (st_r.buf_cnt != 2'h0 && !cfg_drive) begin
                    pop = 1'b1;
                    st_nxt.tx_shift = st_r.buf_word[0];
                    st_nxt.xfer = dpb_pkg::DPB_WAIT;
                    st_nxt.busy = 1'b1;
                end
            end
            dpb_pkg::DPB_WAIT: begin
                // Target pulls its data line low when ready
                if (looped || !SERIAL_DATA_FROM_TARGET) begin
                    st_nxt.xfer = dpb_pkg::DPB_SHIFT;
                    st_nxt.sdo = st_r.tx_shift[7];
                    st_nxt.tx_shift = {st_r.tx_shift[6:0], 1'b0};
                    st_nxt.bit_cnt = 4'h0;
                    st_nxt.half_cnt = half_of(st_r.csr.divider);
                end
            end
            dpb_pkg::DPB_SHIFT: begin
                if (st_r.half_cnt > HALF_W'(1)) begin
                    st_nxt.half_cnt = st_r.half_cnt - HALF_W'(1);
                end else begin
                    st_nxt.half_cnt = half_of(st_r.csr.divider);
                    st_nxt.sck = !st_r.sck;
                    if (!st_r.sck) begin
                        // Rising edge: take the returning bit
                        st_nxt.rx_shift = {st_r.rx_shift[6:0], rx_bit};
                        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
                    end else if (st_r.bit_cnt == dpb_pkg::BITS_PER_BYTE)
                    begin
                        st_nxt.rx_data = st_r.rx_shift;
                        st_nxt.csr.cut_flag = 1'b0;
                        st_nxt.xfer = dpb_pkg::DPB_IDLE;
                        st_nxt.busy = 1'b0;
                    end else begin
                        // Falling edge: next bit, MSB first
                        st_nxt.sdo = st_r.tx_shift[7];
                        st_nxt.tx_shift = {st_r.tx_shift[6:0], 1'b0};
                    end
                end
            end
            default: begin
                st_nxt.xfer = dpb_pkg::DPB_IDLE;
            end
        endcase

        // Outside loopback, a target reset mid-byte cuts it short and flags it
        if (st_r.xfer != dpb_pkg::DPB_IDLE && target_rst && !looped) begin
            st_nxt.csr.cut_flag = 1'b1;
            st_nxt.xfer = dpb_pkg::DPB_IDLE;
            st_nxt.sck = 1'b0;
            st_nxt.busy = 1'b0;
        end

        // Two-entry buffer; a push in the pop cycle lands behind
        if (pop) begin
            st_nxt.buf_word[0] = st_r.buf_word[1];
        end
        if (push) begin
            st_nxt.buf_word[(pop ? st_r.buf_cnt - 2'h1 :
                st_r.buf_cnt) == 2'h0 ? 0 : 1] = HOST_WDATA;
        end
        st_nxt.buf_cnt = st_r.buf_cnt + {1'b0, push} - {1'b0, pop};
        st_nxt.wready = HOST_CONNECTED &&
            (st_nxt.buf_cnt != dpb_pkg::BUF_DEPTH);

        // Soft reset with the debug entry configuration around it
        st_nxt.srst_cnt = st_r.srst_cnt - 16'h0001;
        unique case (st_r.srst)
            dpb_pkg::DPB_SR_OFF: begin
                if (selected && HOST_SOFT_RESET) begin
                    st_nxt.srst = dpb_pkg::DPB_SR_HOLD;
                end
            end
            dpb_pkg::DPB_SR_HOLD: begin
                if (!(selected && HOST_SOFT_RESET)) begin
                    st_nxt.srst = dpb_pkg::DPB_SR_PRE;
                    st_nxt.srst_cnt = 16'(PRE_CYC);
                end
            end
            dpb_pkg::DPB_SR_PRE: begin
                if (st_r.srst_cnt <= 16'h0001) begin
                    st_nxt.srst = dpb_pkg::DPB_SR_POST;
                    st_nxt.srst_cnt = 16'(POST_CYC);
                end
            end
            dpb_pkg::DPB_SR_POST: begin
                if (st_r.srst_cnt <= 16'h0001) begin
                    st_nxt.srst = dpb_pkg::DPB_SR_OFF;
                end
            end
        endcase
        st_nxt.soft_line_oe = st_nxt.srst == dpb_pkg::DPB_SR_HOLD ||
            st_nxt.srst == dpb_pkg::DPB_SR_PRE;
        st_nxt.hreset_oe = selected && HOST_HARD_RESET;

        // Config phase: clock high asks for halt, data low keeps async
        if (st_nxt.srst != dpb_pkg::DPB_SR_OFF) begin
            st_nxt.sck = !st_r.csr.halt_entry_n;
            st_nxt.sdo = 1'b0;
        end

        st_nxt.req = HOST_CONNECTED && !st_nxt.csr.status_req_n;
        st_nxt.sck_oe = HOST_CONNECTED;
        st_nxt.sdo_oe = HOST_CONNECTED && !(looped &&
            st_nxt.srst == dpb_pkg::DPB_SR_OFF);

        // Cable pulled: release every debug line, drop queued bytes
        if (!HOST_CONNECTED) begin
            st_nxt.xfer = dpb_pkg::DPB_IDLE;
            st_nxt.srst = dpb_pkg::DPB_SR_OFF;
            st_nxt.buf_cnt = 2'h0;
            st_nxt.busy = 1'b0;
            st_nxt.sck = 1'b0;
            st_nxt.soft_line_oe = 1'b0;
            st_nxt.hreset_oe = 1'b0;
        end
    end

    // One register bank holds the whole bridge state
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            st_r <= STATE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign HOST_RDATA = st_r.rdata;
    assign HOST_RVALID = st_r.rvalid;
    assign HOST_WREADY = st_r.wready;
    assign HOST_REQUEST_LINE = st_r.req;
    assign XFER_BUSY = st_r.busy;
    assign SERIAL_DEBUG_CLOCK_O = st_r.sck;
    assign SERIAL_DEBUG_CLOCK_OE = st_r.sck_oe;
    assign SERIAL_DATA_TO_TARGET_O = st_r.sdo;
    assign SERIAL_DATA_TO_TARGET_OE = st_r.sdo_oe;
    // Reset lines are open drain: only ever pulled low
    assign SOFT_RESET_LINE_O = 1'b0;
    assign SOFT_RESET_LINE_OE = st_r.soft_line_oe;
    assign HARD_RESET_LINE_O = 1'b0;
    assign HARD_RESET_LINE_OE = st_r.hreset_oe;

endmodule // dpb_bridge

// File: sim/dpb_bridge_sva.sv
/* Port checker for the debug bridge.
   Assumes one MCLK domain and binding to dpb_bridge. */
`timescale 1ns/10ps
module dpb_bridge_sva (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic HOST_CONNECTED,
    input wire logic [2:0] BOARD_ADDR,
    input wire logic [2:0] HOST_BOARD_SEL,
    input wire logic HOST_DATA_SEL,
    input wire logic HOST_STB,
    input wire logic HOST_WR,
    input wire logic HOST_SOFT_RESET,
    input wire logic TARGET_SOFT_RESET_N_IN,
    input wire logic [1:0] TARGET_RUN_STATE_PAIR,
    input wire logic [7:0] HOST_RDATA,
    input wire logic HOST_RVALID,
    input wire logic HOST_REQUEST_LINE,
    input wire logic XFER_BUSY,
    input wire logic SERIAL_DEBUG_CLOCK_O,
    input wire logic SERIAL_DEBUG_CLOCK_OE,
    input wire logic SERIAL_DATA_TO_TARGET_O,
    input wire logic SERIAL_DATA_TO_TARGET_OE,
    input wire logic SOFT_RESET_LINE_OE
);
    // Access taken by this board
    logic hit;
    assign hit = HOST_CONNECTED && HOST_STB && HOST_BOARD_SEL == BOARD_ADDR;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    sequence s_ctl_rd;
        hit && !HOST_WR && !HOST_DATA_SEL;
    endsequence
    sequence s_pre;
        SOFT_RESET_LINE_OE [*2];
    endsequence
    sequence s_cfg;
        ($stable(SERIAL_DEBUG_CLOCK_O) && !SERIAL_DATA_TO_TARGET_O) [*8];
    endsequence
    a_read_answer: assert property (
        hit && !HOST_WR |=> HOST_RVALID) else $error("read unanswered");
    a_wrong_board: assert property (
        HOST_STB && HOST_BOARD_SEL != BOARD_ADDR |=> !HOST_RVALID)
        else $error("foreign board answered");
    a_cable_off: assert property (
        !HOST_CONNECTED |=> !SERIAL_DEBUG_CLOCK_OE
        && !SERIAL_DATA_TO_TARGET_OE && !HOST_REQUEST_LINE)
        else $error("driving without cable");
    a_reset_flag: assert property (
        s_ctl_rd and (!TARGET_SOFT_RESET_N_IN
        && $past(!TARGET_SOFT_RESET_N_IN)) |=> HOST_RDATA[7])
        else $error("reset flag low");
    a_halt_flag: assert property (
        s_ctl_rd and (TARGET_RUN_STATE_PAIR == 2'h3
        && $past(TARGET_RUN_STATE_PAIR) == 2'h3) |=> HOST_RDATA[5])
        else $error("halt flag low");
    a_data_stable: assert property (
        $rose(SERIAL_DEBUG_CLOCK_O) && XFER_BUSY
        |-> $stable(SERIAL_DATA_TO_TARGET_O)) else $error("data moved");
    a_half_min: assert property (
        $rose(SERIAL_DEBUG_CLOCK_O) && XFER_BUSY
        |=> SERIAL_DEBUG_CLOCK_O || !XFER_BUSY) else $error("clock short");
    a_rdata_hold: assert property (
        $changed(HOST_RDATA) |-> HOST_RVALID) else $error("rdata moved");
    a_cfg_hold: assert property (
        $fell(HOST_SOFT_RESET) && SOFT_RESET_LINE_OE && HOST_CONNECTED
        |=> s_pre ##1 s_cfg) else $error("config not held");
endmodule // dpb_bridge_sva
bind dpb_bridge dpb_bridge_sva chk (.*);

// File: sim/dpb_target_model.sv
/* Target debug port model: takes data on the rising serial clock,
   answers on the falling one; first bit out is the ready zero.
   Assumes lines already resolved with the target pull-downs. */
`timescale 1ns/10ps
module dpb_target_model (
    input wire logic mclk,
    input wire logic sck,
    input wire logic sdi,
    input wire logic stall,
    input wire logic [7:0] reply,
    output logic sdo,
    output logic [7:0] got,
    output logic [3:0] rises
);
    logic sck_q = 1'b0;
    logic [2:0] falls = 3'h0;
    initial got = 8'h00;
    initial rises = 4'h0;
    // Edge detect on MCLK; stall also clears a cut byte
    always @(posedge mclk) begin
        sck_q <= sck;
        if (sck && !sck_q) begin
            got <= {got[6:0], sdi};
            rises <= rises + 4'h1;
        end
        if (!sck && sck_q) falls <= falls + 3'h1;
        if (stall) falls <= 3'h0;
    end
    // High while busy, low means ready; reply bits follow falls
    assign sdo = (falls == 3'h0) ? stall : reply[3'h7 - falls];
endmodule // dpb_target_model

// File: sim/dpb_bridge_test.sv
/* Self-checking bench of the debug bridge with a target model.
   Assumes the checker binds itself to the bridge. */
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
    $display("FAIL %0t got %h exp %h", $time, a, b); end end
module dpb_bridge_test;
    logic clk = 1'b0, nrst = 1'b0, conn = 1'b1, dsel = 1'b0, stb = 1'b0;
    logic wr = 1'b0, srst = 1'b0, trs_n = 1'b0, stall = 1'b0, rv, wrdy;
    logic hrst = 1'b0, trh_n = 1'b1, hr_oe, sr_o, hr_o;
    logic req, busy, sck_o, sck_oe, sdo_o, sdo_oe, sr_oe, sdi_w, sck_w, t_sdo;
    logic [2:0] bsel = 3'h5;
    logic [1:0] rsp = 2'h0;
    logic [7:0] wd = 8'h00, reply = 8'h3C, rd, got, v;
    logic [3:0] rises, r0;
    int num_errors = 0;
    int checked = 0;
    always #12.5 clk = ~clk;
    // Released lines fall to the target pull-downs
    assign sdi_w = sdo_oe ? sdo_o : 1'b0;
    assign sck_w = sck_oe ? sck_o : 1'b0;
    dpb_bridge dut (.MCLK(clk), .NRST(nrst), .HOST_CONNECTED(conn),
        .BOARD_ADDR(3'h5), .HOST_BOARD_SEL(bsel), .HOST_DATA_SEL(dsel),
        .HOST_STB(stb), .HOST_WR(wr), .HOST_WDATA(wd),
        .HOST_SOFT_RESET(srst), .HOST_HARD_RESET(hrst), .HOST_RDATA(rd),
        .HOST_RVALID(rv), .HOST_WREADY(wrdy), .HOST_REQUEST_LINE(req),
        .XFER_BUSY(busy), .TARGET_SOFT_RESET_N_IN(trs_n),
        .TARGET_HRESET_N_IN(trh_n), .TARGET_RUN_STATE_PAIR(rsp),
        .SERIAL_DATA_FROM_TARGET(t_sdo), .SERIAL_DEBUG_CLOCK_O(sck_o),
        .SERIAL_DEBUG_CLOCK_OE(sck_oe), .SERIAL_DATA_TO_TARGET_O(sdo_o),
        .SERIAL_DATA_TO_TARGET_OE(sdo_oe), .SOFT_RESET_LINE_O(sr_o),
        .SOFT_RESET_LINE_OE(sr_oe), .HARD_RESET_LINE_O(hr_o),
        .HARD_RESET_LINE_OE(hr_oe));
    dpb_target_model tgt (.mclk(clk), .sck(sck_w), .sdi(sdi_w),
        .stall(stall), .reply(reply), .sdo(t_sdo), .got(got), .rises(rises));
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Bounded wait, sampled on the falling edge, clear of any launch
    task automatic hold(ref logic s, input logic lv);
        int i;
        for (i = 0; i < 4000; i++) begin
            @(negedge clk);
            if (s === lv) break;
        end
        if (s !== lv) begin
            num_errors++;
            conclude();
        end
    endtask
    task automatic acc(input logic d, input logic w, input logic [7:0] x);
        @(posedge clk);
        dsel <= d;
        wr <= w;
        wd <= x;
        stb <= 1'b1;
        @(posedge clk);
        stb <= 1'b0;
    endtask
    task automatic rdr(input logic d);
        acc(d, 1'b0, 8'h00);
        #1;
        hold(rv, 1'b1);
        v = rd;
        @(posedge clk);
    endtask
    task automatic send(input logic [7:0] b);
        hold(wrdy, 1'b1);
        acc(1'b1, 1'b1, b);
        hold(busy, 1'b1);
    endtask
    task automatic t_regs();
        rdr(1'b0);
        `CHK(v, 8'h80)
        `CHK(req, 1'b1)
        trs_n <= 1'b1;
        rsp <= 2'h3;
        acc(1'b0, 1'b1, 8'hFF);
        rdr(1'b0);
        `CHK(v, 8'h3F)
        `CHK(req, 1'b0)
        bsel <= 3'h2;
        rsp <= 2'h0;
        acc(1'b0, 1'b1, 8'h00);
        acc(1'b0, 1'b0, 8'h00);
        #1;
        `CHK(rv, 1'b0)
        @(posedge clk);
        bsel <= 3'h5;
        rdr(1'b0);
        `CHK(v, 8'h1F)
        $display("done registers");
    endtask
    task automatic t_serial();
        int d, n;
        acc(1'b0, 1'b1, 8'h00);
        send(8'hA5);
        `CHK(sdo_oe, 1'b0)
        hold(busy, 1'b0);
        rdr(1'b1);
        `CHK(v, 8'hA5)
        for (d = 0; d < 4; d++) begin
            acc(1'b0, 1'b1, {3'h0, d[1:0], 3'h7});
            send(8'h96 ^ 8'(d));
            hold(sck_o, 1'b1);
            for (n = 0; n < 40 && sck_o === 1'b1; n++) @(negedge clk);
            `CHK(n, 2 << d)
            hold(busy, 1'b0);
            `CHK(got, 8'h96 ^ 8'(d))
            rdr(1'b1);
            `CHK(v, {1'b0, reply[6:0]})
        end
        $display("done serial");
    endtask
    task automatic t_buffer();
        int k;
        acc(1'b0, 1'b1, 8'h07);
        stall <= 1'b1;
        r0 = rises;
        for (k = 0; k < 3; k++) acc(1'b1, 1'b1, 8'hC1 + 8'(k));
        repeat (20) @(posedge clk);
        `CHK(wrdy, 1'b0)
        `CHK(rises, r0)
        stall <= 1'b0;
        for (k = 0; k < 3; k++) begin
            hold(busy, 1'b1);
            hold(busy, 1'b0);
        end
        `CHK(got, 8'hC3)
        $display("done buffer");
    endtask
    task automatic t_abort();
        acc(1'b0, 1'b1, 8'h1F);
        send(8'h5A);
        repeat (40) @(posedge clk);
        trs_n <= 1'b0;
        hold(busy, 1'b0);
        rdr(1'b0);
        `CHK(v[7:6], 2'h3)
        `CHK(sck_o, 1'b0)
        trs_n <= 1'b1;
        stall <= 1'b1;
        acc(1'b0, 1'b1, 8'h07);
        stall <= 1'b0;
        send(8'h33);
        hold(busy, 1'b0);
        rdr(1'b0);
        `CHK(v[6], 1'b0)
        $display("done abort");
    endtask
    task automatic t_pins();
        // Hard reset only: the flag must still come up
        hrst <= 1'b1;
        trh_n <= 1'b0;
        rdr(1'b0);
        `CHK(v[7], 1'b1)
        `CHK({hr_oe, hr_o, sr_o}, 3'h4)
        hrst <= 1'b0;
        trh_n <= 1'b1;
        conn <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK({sck_oe, sdo_oe, req, wrdy}, 4'h0)
        conn <= 1'b1;
        acc(1'b0, 1'b1, 8'h06);
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK({sr_oe, sck_o, sdo_o}, 3'h6)
        srst <= 1'b0;
        repeat (16) @(posedge clk);
        `CHK(sr_oe, 1'b0)
        $display("done pins");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_serial();
        t_buffer();
        t_abort();
        t_pins();
        conclude();
    end
endmodule // dpb_bridge_test
